// File: verilog/cjm_cfg.svh
/*
 Constants for the jump, copy and idle instruction executor.
 Assumes a 16-bit instruction word, 16-bit program counter, status flags C, Z, N, V.
*/
`ifndef CJM_CFG_SVH
`define CJM_CFG_SVH
`define CJM_JMP_OP_HI      15
`define CJM_JMP_OP_LO      13
`define CJM_JMP_OPCODE     3'h1
`define CJM_COND_HI        12
`define CJM_COND_LO        10
`define CJM_OFS_HI         9
`define CJM_FMT1_OP_HI     15
`define CJM_FMT1_OP_LO     12
`define CJM_COPY_OPCODE    4'h4
`define CJM_SRC_HI         11
`define CJM_SRC_LO         8
`define CJM_DST_HI         3
`define CJM_DST_LO         0
`define CJM_CG_REG         4'h3
`define CJM_PC_STEP        16'h0002
`define CJM_BYTE_BIT       6
`define CJM_BYTE_MASK      16'h00ff
`define CJM_PC_RESET       16'h0000
`define CJM_FLAG_C         0
`define CJM_FLAG_Z         1
`define CJM_FLAG_N         2
`define CJM_FLAG_V         8
`endif

// File: verilog/cjm_pkg.sv
/*
 Types for the jump, copy and idle instruction executor.
 Assumes the constants header is included by the design files.
*/
package cjm_pkg;
    typedef enum logic [2:0] {
        CJM_COND_NC = 3'h0,
        CJM_COND_NZ = 3'h1,
        CJM_COND_Z  = 3'h2,
        CJM_COND_C  = 3'h3,
        CJM_COND_N  = 3'h4,
        CJM_COND_GE = 3'h5,
        CJM_COND_L  = 3'h6,
        CJM_COND_AL = 3'h7
    } cjm_cond_t;
    typedef enum logic [1:0] {
        CJM_ST_IDLE = 2'h0,
        CJM_ST_EXEC = 2'h1
    } cjm_state_t;
endpackage : cjm_pkg

// File: verilog/cjm_cond_eval.sv
/*
 Condition evaluator: decides whether a relative jump is taken.
 Assumes flags are stable levels from the core status register.
*/
`timescale 1ns/1ps
`include "cjm_cfg.svh"
module cjm_cond_eval (
    // Condition code
    input  wire logic [2:0] cond,
    // Status flags
    input  wire logic       flag_c,
    input  wire logic       flag_z,
    input  wire logic       flag_n,
    input  wire logic       flag_v,
    // Decision
    output logic            taken
);
    always_comb
    begin
        case (cjm_pkg::cjm_cond_t'(cond))
            cjm_pkg::CJM_COND_C:  taken = flag_c;
            cjm_pkg::CJM_COND_NC: taken = ~flag_c;
            cjm_pkg::CJM_COND_Z:  taken = flag_z;
            cjm_pkg::CJM_COND_NZ: taken = ~flag_z;
            cjm_pkg::CJM_COND_N:  taken = flag_n;
            cjm_pkg::CJM_COND_GE: taken = ~(flag_n ^ flag_v);
            cjm_pkg::CJM_COND_L:  taken = flag_n ^ flag_v;
            default:              taken = 1'b1;
        endcase
    end
endmodule : cjm_cond_eval

// File: verilog/cjm_exec.sv
/*
 Executor for relative jumps, the operand copy and the idle instruction.
 Assumes the core fetches a word, presents it with instr_valid for one cycle,
 supplies the already fetched source operand value, and writes back results.
*/
// The plain strobed port and the register offsets were decided locally.
// How it works
// - carry set takes the jump
// - carry clear takes the jump
// - zero set takes the jump
// - zero clear takes the jump
// - negative set takes the jump
// - N xor V clear takes the jump
// - N xor V set takes the jump
// - unconditional jump always adds doubled offset
// - copy writes source, or only its low byte when bit 6 is set, flags and modes untouched
// - idle changes nothing, decoded from any copy to R3, whatever the source
`timescale 1ns/1ps
`include "cjm_cfg.svh"
module cjm_exec (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Instruction in
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [15:0] src_value,
    // Status register in
    input  wire logic [15:0] status_in,
    // Program counter out
    output logic      [15:0] pc,
    // Result write back
    output logic             wr_en,
    output logic      [3:0]  wr_reg,
    output logic      [15:0] wr_data,
    output logic      [15:0] status_out,
    // Classification
    output logic             is_jump,
    output logic             jump_taken,
    output logic             is_copy,
    output logic             is_idle,
    output logic             unsupported
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic [15:0] cjm_ofs2(input logic [15:0] w);
        cjm_ofs2 = {{5{w[`CJM_OFS_HI]}}, w[`CJM_OFS_HI:0], 1'b0};
    endfunction : cjm_ofs2

    logic dec_jump;
    logic dec_copy;
    logic dec_idle;
    logic cond_ok;
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;

    assign dec_jump = instr_word[`CJM_JMP_OP_HI:`CJM_JMP_OP_LO] == `CJM_JMP_OPCODE;
    assign dec_copy = instr_word[`CJM_FMT1_OP_HI:`CJM_FMT1_OP_LO] == `CJM_COPY_OPCODE;
    assign dec_idle = dec_copy && instr_word[`CJM_DST_HI:`CJM_DST_LO] == `CJM_CG_REG;

    cjm_cond_eval u_cond (
        .cond   (instr_word[`CJM_COND_HI:`CJM_COND_LO]),
        .flag_c (status_in[`CJM_FLAG_C]),
        .flag_z (status_in[`CJM_FLAG_Z]),
        .flag_n (status_in[`CJM_FLAG_N]),
        .flag_v (status_in[`CJM_FLAG_V]),
        .taken  (cond_ok)
    );

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    always_comb
    begin
        pc_nxt = pc_r;
        if (instr_valid)
        begin
            if (dec_jump && cond_ok)
                pc_nxt = 16'(pc_r + `CJM_PC_STEP + cjm_ofs2(instr_word));
            else
                pc_nxt = 16'(pc_r + `CJM_PC_STEP);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pc_r <= `CJM_PC_RESET;
        else
            pc_r <= pc_nxt;
    end
    assign pc = pc_r;

    // ----------------------------------------------------------------
    // Write back and status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wr_en      <= 1'b0;
            wr_reg     <= 4'h0;
            wr_data    <= 16'h0000;
            status_out <= 16'h0000;
        end
        else
        begin
            wr_en      <= instr_valid && dec_copy && !dec_idle;
            wr_reg     <= instr_word[`CJM_DST_HI:`CJM_DST_LO];
            wr_data    <= instr_word[`CJM_BYTE_BIT] ? (src_value & `CJM_BYTE_MASK)
                                                    : src_value;
            status_out <= status_in;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            is_jump     <= 1'b0;
            jump_taken  <= 1'b0;
            is_copy     <= 1'b0;
            is_idle     <= 1'b0;
            unsupported <= 1'b0;
        end
        else
        begin
            is_jump     <= instr_valid && dec_jump;
            jump_taken  <= instr_valid && dec_jump && cond_ok;
            is_copy     <= instr_valid && dec_copy && !dec_idle;
            is_idle     <= instr_valid && dec_idle;
            unsupported <= instr_valid && !dec_jump && !dec_copy;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_carry_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h3 && status_in[0]
        |=> pc == 16'($past(pc) + 16'h0002 + $past(cjm_ofs2(instr_word))))
        else $error("carry jump target wrong");
    chk_nocarry_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h0 && status_in[0]
        |=> pc == 16'($past(pc) + 16'h0002))
        else $error("no-carry jump taken with carry set");
    chk_zero_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h2 |=> jump_taken == $past(status_in[1]))
        else $error("zero jump decision wrong");
    chk_nonzero_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h1 |=> jump_taken != $past(status_in[1]))
        else $error("nonzero jump decision wrong");
    chk_neg_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h4 |=> jump_taken == $past(status_in[2]))
        else $error("negative jump decision wrong");
    chk_ge_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h5
        |=> jump_taken == !($past(status_in[2]) ^ $past(status_in[8])))
        else $error("signed ge decision wrong");
    chk_lt_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h6
        |=> jump_taken == ($past(status_in[2]) ^ $past(status_in[8])))
        else $error("signed lt decision wrong");
    chk_always_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump && instr_word[12:10] == 3'h7 |=> jump_taken)
        else $error("unconditional jump not taken");
    chk_copy_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_copy && !dec_idle && !instr_word[6]
        |=> wr_en && wr_data == $past(src_value) && status_out == $past(status_in))
        else $error("copy result or status wrong");
    chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_idle |=> !wr_en && status_out == $past(status_in))
        else $error("idle changed state");
    chk_jump_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dec_jump |=> !wr_en && status_out == $past(status_in))
        else $error("jump altered flags");

    cov_jump_taken: cover property (@(posedge sys_clk) disable iff (!rst_n) jump_taken);
    cov_jump_fall: cover property (@(posedge sys_clk) disable iff (!rst_n) is_jump && !jump_taken);
    cov_copy: cover property (@(posedge sys_clk) disable iff (!rst_n) is_copy);
    cov_idle: cover property (@(posedge sys_clk) disable iff (!rst_n) is_idle);
endmodule : cjm_exec

// File: dv/test_cpu_jump_move_nop_exec.sv
/*
 Self-checking bench for the jump, copy and idle instruction executor.
 Assumes one clock, synchronous active-low reset, answers one cycle after instr_valid.
*/
`timescale 1ns/1ps
`include "cjm_cfg.svh"
module test_cpu_jump_move_nop_exec;
    typedef struct {
        logic [3:0]  kind;
        logic [15:0] pc;
        logic        tk;
        logic [15:0] dat;
        logic [15:0] st;
        logic [3:0]  rg;
    } cjm_exp_t;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] src_value = 16'h0000;
    logic [15:0] status_in = 16'h0000;
    logic [15:0] pc, wr_data, status_out;
    logic [3:0]  wr_reg;
    logic        wr_en, is_jump, jump_taken, is_copy, is_idle, unsupported;
    int          n_errors = 0;
    int          check_count = 0;
    logic [15:0] pc_m = 16'h0000;
    cjm_exp_t    q[$];
    cjm_exp_t    e;
    always #2 sys_clk = ~sys_clk;
    cjm_exec DUT (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .src_value(src_value), .status_in(status_in), .pc(pc),
        .wr_en(wr_en), .wr_reg(wr_reg), .wr_data(wr_data), .status_out(status_out),
        .is_jump(is_jump), .jump_taken(jump_taken), .is_copy(is_copy), .is_idle(is_idle),
        .unsupported(unsupported));
    // ----------------------------------------
    // Compare and closing tasks
    // ----------------------------------------
    task automatic chk16(input logic [15:0] x, input logic [15:0] g);
        check_count++;
        if (g !== x)
        begin
            n_errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask : chk16
    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    function automatic logic tk_f(input logic [2:0] c, input logic [15:0] s);
        case (c)
            3'h0: return ~s[0];
            3'h1: return ~s[1];
            3'h2: return s[1];
            3'h3: return s[0];
            3'h4: return s[2];
            3'h5: return ~(s[2] ^ s[8]);
            3'h6: return s[2] ^ s[8];
            default: return 1'b1;
        endcase
    endfunction : tk_f
    // Drives one instruction and notes what should come out
    task automatic issue(input logic [15:0] w, input logic [15:0] s, input logic [15:0] st);
        cjm_exp_t x;
        x.st = st;
        x.rg = w[3:0];
        x.tk = 1'b0;
        x.dat = w[6] ? {8'h00, s[7:0]} : s;
        if (w[15:13] == 3'h1)
        begin
            x.kind = 4'h1;
            x.tk = tk_f(w[12:10], st);
        end
        else if (w[15:12] == 4'h4)
            x.kind = (w[3:0] == 4'h3) ? 4'h4 : 4'h2;
        else
            x.kind = 4'h8;
        pc_m = pc_m + 16'h0002 + (x.tk ? {{5{w[9]}}, w[9:0], 1'b0} : 16'h0000);
        x.pc = pc_m;
        q.push_back(x);
        instr_valid <= 1'b1;
        instr_word <= w;
        src_value <= s;
        status_in <= st;
        @(posedge sys_clk);
    endtask : issue
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(negedge sys_clk)
    begin
        if (rst_n === 1'b1 && (is_jump | is_copy | is_idle | unsupported) === 1'b1)
        begin
            e = q.pop_front();
            chk16({12'h0, e.kind}, {12'h0, unsupported, is_idle, is_copy, is_jump});
            chk16(e.pc, pc);
            chk16({15'h0, e.tk}, {15'h0, jump_taken});
            chk16(e.st, status_out);
            chk16({15'h0, e.kind == 4'h2}, {15'h0, wr_en});
            if (e.kind == 4'h2)
            begin
                chk16(e.dat, wr_data);
                chk16({12'h0, e.rg}, {12'h0, wr_reg});
            end
        end
    end
    initial
    begin
        #40000;
        n_errors++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h12e3));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk16(16'h0000, pc);
        issue(16'h3dff, $urandom, $urandom);
        issue(16'h3e00, $urandom, $urandom);
        for (int c = 0; c < 8; c++)
            for (int f = 0; f < 16; f++)
                issue({3'h1, c[2:0], 10'($urandom)},
                      $urandom, ($urandom & 16'hfef8) | {7'h0, f[3], 5'h0, f[2:0]});
        for (int i = 0; i < 300; i++)
        begin
            case ($urandom % 4)
                0: issue({3'h1, 13'($urandom)}, $urandom, $urandom);
                1: issue({4'h4, 12'($urandom)}, $urandom, $urandom);
                2: issue({4'h4, 8'($urandom), 4'h3}, $urandom, $urandom);
                default: issue({4'h0, 12'($urandom)}, $urandom, $urandom);
            endcase
        end
        instr_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk16(16'h0000, 16'(q.size()));
        tally_and_finish();
    end
endmodule : test_cpu_jump_move_nop_exec
